/* File: bench/hbss_flash.sv */
// Serial flash model serving one four-byte word
`timescale 1ns/1ps
module hbss_flash (
  input wire          sck,  // Serial clock
  input wire          cs_n, // Select, active low
  input wire          mosi, // Command and address bits
  input wire          dual, // Two data lines
  input wire   [31:0] word, // Word at the signature address
  output logic        miso, // Data, high bit in dual mode
  output logic        io0,  // Low bit in dual mode
  output logic [23:0] hdr   // Opcode and address seen
);
  int n;
  int k;
  initial miso = 1'h1;
  initial io0 = 1'h0;
  always @(negedge cs_n) begin
    n = 0;
    k = 31;
  end
  // Sample on rising, shift on falling: serves modes 0 and 3 alike
  always @(posedge sck) if (!cs_n && n < 24) begin
    hdr = {hdr[22:0], mosi};
    n = n + 1;
  end
  // Keeps up with any clock rate, like a large fast part
  always @(negedge sck) if (!cs_n && n == 24 && k >= 0) begin
    miso = word[k];
    io0 = dual ? word[k-1] : ~io0;
    k = dual ? k - 2 : k - 1;
  end
  // Deselected lines float; invert so a stale bit never passes
  always @(posedge cs_n) begin
    miso = ~miso;
    io0 = ~io0;
  end
endmodule // hbss_flash

/* File: bench/hbss_sequencer_tb.sv */
// Self-checking bench for the hub boot stage sequencer
`timescale 1ns/1ps
`include "hbss_consts.vh"
module hbss_sequencer_tb;
  logic        REF_CLK = 1'h0, RESET = 1'h1, PLL_CLK_OK = 1'h0, SPI_MODE_STRAP = 1'h0;
  logic        SPI_DUAL = 1'h0, SPI_CPOL = 1'h0, MGMT_DATA_IN = 1'h1, MGMT_CLOCK_IN = 1'h1;
  logic        SOC_WR = 1'h0, BC_EN = 1'h0, VBUS = 1'h0, CHG_DONE = 1'h0, MODE_CHANGE = 1'h0;
  logic        GPIO_WR = 1'h0, BRIDGE_REQ = 1'h0, SPI_MISO, SPI_IO0_IN, fio0;
  logic [2:0]  PRESET_STRAP = 3'h0;
  logic [7:0]  SOC_ADDR = 8'h00, GPIO_WDATA = 8'h00, BRIDGE_WDATA = 8'h00;
  logic [7:0]  BRIDGE_RDATA_IN = 8'h00, GPIO_OUT, BRIDGE_WOUT, BRIDGE_RDATA, gp;
  logic [15:0] STRAP_CFG = 16'h0000, STRAP_MASK = 16'h0000, SOC_DATA = 16'h0000;
  logic [15:0] OTP_DATA = 16'h0000, OTP_VALID = 16'h0000, EXEC_ADDR, CONFIG, br;
  logic        SPI_SCK, SPI_CS_N, SPI_IO0_OUT, SPI_IO0_OE, PLL_EN, PORT_OE, PORTS_EN;
  logic        EXT_EXEC, MGMT_SLAVE, USB_CONNECT, SUSPEND;
  logic [9:0]  STAGE;
  logic [31:0] word, r = 32'hD791BE63;
  logic [23:0] hdr;
  int          mismatches = 0, checks = 0, t, k;
  initial forever #25 REF_CLK = ~REF_CLK;
  assign SPI_IO0_IN = SPI_IO0_OE ? SPI_IO0_OUT : fio0;
  hbss_sequencer i_hbss_sequencer (.*);
  hbss_flash i_hbss_flash (.sck(SPI_SCK), .cs_n(SPI_CS_N), .mosi(SPI_IO0_IN), .dual(SPI_DUAL),
    .word(word), .miso(SPI_MISO), .io0(fio0), .hdr(hdr));
  function automatic logic [31:0] rnd();
    r = r ^ (r << 13);
    r = r ^ (r >> 17);
    r = r ^ (r << 5);
    return r;
  endfunction
  task automatic tick();
    @(posedge REF_CLK);
    #1;
  endtask
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] s);
    checks++;
    if (s !== e) begin
      mismatches++;
      $display("MISMATCH %s expected %h seen %h", n, e, s);
    end
  endtask
  // Waits for the next stage change, bounded
  task automatic step(input logic [9:0] e);
    logic [9:0] s;
    int i;
    s = STAGE;
    for (i = 0; i < 400 && STAGE === s; i++) tick();
    if (i == 400) begin
      mismatches++;
      give_verdict();
    end
    else chk("STAGE", e, STAGE);
  endtask
  task automatic boot(input logic sp, du, pr, pu);
    RESET = 1'h1;
    VBUS = 1'h0;
    BC_EN = 1'h0;
    PLL_CLK_OK = 1'h0;
    SPI_MODE_STRAP = sp;
    SPI_DUAL = du;
    SPI_CPOL = du;
    PRESET_STRAP = pr ? `HBSS_PRESET_SLAVE : `HBSS_PRESET_I2C;
    MGMT_CLOCK_IN = pu;
    gp = 8'h00;
    br = 16'h0000;
    tick();
    chk("STANDBY", 32'h00440000, {STAGE, PORT_OE, PORTS_EN, PLL_EN, SPI_CS_N, SPI_IO0_OE,
      USB_CONNECT, CONFIG});
    repeat (7) tick();
    RESET = 1'h0;
    // Without a valid clock the lock never completes
    repeat (30) tick();
    chk("INIT", 32'h003, {STAGE, PLL_EN});
    PLL_CLK_OK = 1'h1;
  endtask
  task automatic poke(input logic gok, bok);
    GPIO_WDATA = 8'(rnd());
    BRIDGE_WDATA = 8'(rnd());
    BRIDGE_RDATA_IN = 8'(rnd());
    GPIO_WR = 1'h1;
    BRIDGE_REQ = 1'h1;
    tick();
    GPIO_WR = 1'h0;
    BRIDGE_REQ = 1'h0;
    tick();
    if (gok) gp = GPIO_WDATA;
    if (bok) br = {BRIDGE_WDATA, BRIDGE_RDATA_IN};
    chk("GPIO_BRIDGE", {gp, br}, {GPIO_OUT, BRIDGE_WOUT, BRIDGE_RDATA});
  endtask
  initial begin
    for (t = 0; t < 3; t++) begin
      word = t == 2 ? ~`HBSS_SIG_WORD : `HBSS_SIG_WORD;
      boot(1'h1, t == 1, 1'h0, 1'h0);
      step(10'h002);
      for (k = 0; k < 400 && EXT_EXEC !== 1'h1 && STAGE === 10'h002; k++) tick();
      if (k == 400) begin
        mismatches++;
        give_verdict();
      end
      chk("HDR", {t == 1 ? `HBSS_OP_READ2 : `HBSS_OP_READ1, `HBSS_SIG_ADDR}, hdr);
      chk("EXEC", {t < 2, `HBSS_EXEC_ADDR, t < 2 ? 10'h002 : 10'h004},
        {EXT_EXEC, EXEC_ADDR, STAGE});
      $display("flash test %0d done", t);
    end
    STRAP_CFG = 16'(rnd());
    STRAP_MASK = 16'(rnd());
    OTP_DATA = 16'(rnd());
    OTP_VALID = 16'(rnd());
    SOC_DATA = 16'(rnd());
    SOC_ADDR = 8'(rnd()) & 8'h7F;
    boot(1'h0, 1'h0, 1'h1, 1'h1);
    step(10'h004);
    step(10'h008);
    step(10'h010);
    chk("CFG_RD", {1'h1, (`HBSS_ROM_DEFAULT & ~STRAP_MASK) | (STRAP_CFG & STRAP_MASK)},
      {MGMT_SLAVE, CONFIG});
    poke(1'h1, 1'h0);
    SOC_WR = 1'h1;
    tick();
    SOC_WR = 1'h0;
    repeat (300) tick();
    chk("SOC_WAIT", 10'h010, STAGE);
    SOC_ADDR = `HBSS_SOC_DONE_ADDR;
    SOC_WR = 1'h1;
    step(10'h020);
    SOC_WR = 1'h0;
    step(10'h040);
    tick();
    chk("MERGE", {3'h7, (SOC_DATA & ~OTP_VALID) | (OTP_DATA & OTP_VALID)},
      {PORT_OE, PORTS_EN, SUSPEND, CONFIG});
    VBUS = 1'h1;
    BC_EN = 1'h1;
    step(10'h080);
    CHG_DONE = 1'h1;
    step(10'h100);
    CHG_DONE = 1'h0;
    step(10'h200);
    chk("CONNECT", 32'h1, USB_CONNECT);
    poke(1'h1, 1'h1);
    MODE_CHANGE = 1'h1;
    step(10'h040);
    MODE_CHANGE = 1'h0;
    $display("slave path done");
    boot(1'h0, 1'h0, 1'h1, 1'h0);
    step(10'h004);
    step(10'h008);
    step(10'h020);
    step(10'h040);
    poke(1'h0, 1'h0);
    VBUS = 1'h1;
    step(10'h100);
    step(10'h200);
    boot(1'h0, 1'h0, 1'h0, 1'h1);
    step(10'h004);
    step(10'h008);
    step(10'h020);
    chk("PRESET", 32'h0, MGMT_SLAVE);
    $display("otp path done");
    give_verdict();
  end
endmodule // hbss_sequencer_tb

/* File: bench/hbss_sva.sv */
// Assertions on the ports of the boot stage sequencer
`timescale 1ns/1ps
`include "hbss_consts.vh"
module hbss_sva (
  input wire       REF_CLK, RESET, SPI_MODE_STRAP, MGMT_DATA_IN, MGMT_CLOCK_IN, SOC_WR,
  input wire       BC_EN, VBUS, CHG_DONE, MODE_CHANGE, GPIO_WR, PLL_EN, PORTS_EN, SUSPEND,
  input wire       EXT_EXEC,
  input wire [2:0] PRESET_STRAP,
  input wire [7:0] SOC_ADDR, GPIO_OUT,
  input wire [9:0] STAGE
);
  // ==========================================================================
  // Stage transitions
  default clocking @(posedge REF_CLK); endclocking
  default disable iff (RESET);
  wire fin = SOC_WR && SOC_ADDR == `HBSS_SOC_DONE_ADDR;
  a_release_clean: assert property
    ($fell(RESET) |-> STAGE == 10'h001 && !PORTS_EN ##1 PLL_EN) else $error("bad reset state");
  a_stage_onehot: assert property
    ($onehot(STAGE)) else $error("stage not one-hot");
  a_flash_strap: assert property
    (STAGE == 10'h002 |-> SPI_MODE_STRAP) else $error("flash stage without strap");
  a_strap_route: assert property
    (STAGE == 10'h008 |=> STAGE == (PRESET_STRAP == `HBSS_PRESET_SLAVE && MGMT_DATA_IN
      && MGMT_CLOCK_IN ? 10'h010 : 10'h020)) else $error("wrong stage after strap");
  a_soc_wait: assert property
    (STAGE == 10'h010 && !fin |=> STAGE == 10'h010) else $error("soc stage left early");
  a_soc_done: assert property
    (STAGE == 10'h010 && fin |=> STAGE == 10'h020) else $error("soc stage not ended");
  a_idle_vbus: assert property
    (STAGE == 10'h040 && VBUS |=> STAGE == (BC_EN ? 10'h080 : 10'h100)) else $error("idle exit");
  a_idle_suspend: assert property
    (STAGE == 10'h040 && !VBUS ##1 STAGE == 10'h040 |-> SUSPEND) else $error("idle not suspended");
  a_normal_hold: assert property
    (STAGE == 10'h200 && VBUS && !MODE_CHANGE |=> STAGE == 10'h200) else $error("normal left");
  a_gpio_refused: assert property
    (GPIO_WR && (STAGE & 10'h210) == 10'h000 |=> $stable(GPIO_OUT)) else $error("gpio write taken");
  c_soc_session: cover property (STAGE == 10'h010 ##1 STAGE == 10'h020);
  c_flash_exec: cover property (EXT_EXEC);
  c_normal: cover property (STAGE == 10'h100 ##1 STAGE == 10'h200);
endmodule // hbss_sva
bind hbss_sequencer hbss_sva i_hbss_sva (.*);

/* File: hdl/hbss_consts.vh */
// Constants for the hub boot stage sequencer
`ifndef HBSS_CONSTS_VH
`define HBSS_CONSTS_VH

// Firmware-upgrade signature, four ASCII characters, and where it sits in flash
`define HBSS_SIG_ADDR      16'hFFFA
`define HBSS_SIG_WORD      32'h32444655
`define HBSS_EXEC_ADDR     16'h0000
`define HBSS_SIG_BYTES     3'h4

// Register address whose write ends the SOC configuration window
`define HBSS_SOC_DONE_ADDR 8'hFF

// Preset strap encodings (3-bit decoded resistor value)
`define HBSS_PRESET_I2C    3'h0
`define HBSS_PRESET_SLAVE  3'h1

// Default configuration word loaded from internal ROM
`define HBSS_ROM_DEFAULT   16'h0000
`define HBSS_CFG_W         16

// SPI flash read opcodes for 1-bit and 2-bit transfers
`define HBSS_OP_READ1      8'h03
`define HBSS_OP_READ2      8'h3B

// PLL lock settle time
`define HBSS_LOCK_NS       1000
`define HBSS_CLK_NS        50

`endif

/* File: hdl/hbss_sequencer.v */
// Hub boot stage sequencer: standby, boot stages, connect and normal mode
// ==========================================================================
// How it works
// - Reset high holds standby, outputs floated, PLL stopped
// - Reset low runs hub mode through boot stages
// - Standby aborts work and returns registers to defaults
// - First stage resets logic, locks PLL, loads defaults
// - SPI strap: read flash signature at high address
// - Signature match runs flash from zero, else ROM
// - Without SPI strap skip check to config read
// - Flash reads in single or dual bit mode
// - Flash access works in mode 0 and 3
// - Load ROM defaults then strap overrides
// - Slave preset with both pull-ups enters SOC stage
// - SOC stage waits forever, no timeout
// - Merge ROM, SOC and OTP into configuration
// - Idle then suspend without VBUS or connect
// - VBUS goes to charger detect or connect
// - Connect while VBUS high, leave when it drops
// - Normal mode until system changes operating mode
// - GPIO state written at runtime through registers
// - Bridge I2C and SPI traffic transparently
// - 200k pull-up preset selects management slave mode
`timescale 1ns/1ps
`include "hbss_consts.vh"

module hbss_sequencer (
  input  wire        REF_CLK,        // 20 MHz clock
  input  wire        RESET,          // Chip reset, active high
  input  wire        PLL_CLK_OK,     // Valid reference clock present
  input  wire        SPI_MODE_STRAP, // Strapped for SPI flash mode
  input  wire        SPI_DUAL,       // Use 2-bit flash reads
  input  wire        SPI_CPOL,       // Flash clock idle level, 0 mode 0, 1 mode 3
  input  wire [2:0]  PRESET_STRAP,   // Decoded preset strap
  input  wire [15:0] STRAP_CFG,      // Strap override values
  input  wire [15:0] STRAP_MASK,     // Which bits the straps override
  input  wire        MGMT_DATA_IN,   // Management data pin level
  input  wire        MGMT_CLOCK_IN,  // Management clock pin level
  input  wire        SOC_WR,         // SOC register write strobe
  input  wire [7:0]  SOC_ADDR,       // SOC register address
  input  wire [15:0] SOC_DATA,       // SOC register data
  input  wire [15:0] OTP_DATA,       // OTP configuration word
  input  wire [15:0] OTP_VALID,      // OTP bits programmed
  input  wire        BC_EN,          // Battery charging enabled
  input  wire        VBUS,           // VBUS pin function
  input  wire        CHG_DONE,       // Charger detection finished
  input  wire        MODE_CHANGE,    // System leaves normal mode
  input  wire        GPIO_WR,        // Runtime GPIO register write
  input  wire [7:0]  GPIO_WDATA,     // GPIO value written
  input  wire        BRIDGE_REQ,     // Host bridge request valid
  input  wire [7:0]  BRIDGE_WDATA,   // Host bridge data out
  input  wire [7:0]  BRIDGE_RDATA_IN,// Data from bridged device
  input  wire        SPI_MISO,       // Flash data in 0 / io1
  input  wire        SPI_IO0_IN,     // Flash io0 input in dual mode
  output reg         SPI_SCK,        // Flash clock
  output reg         SPI_CS_N,       // Flash select, active low
  output reg         SPI_IO0_OUT,    // Flash io0 drive
  output reg         SPI_IO0_OE,     // Flash io0 enable
  output reg         PLL_EN,         // PLL running
  output reg         PORT_OE,        // Port interfaces driven
  output reg         PORTS_EN,       // Downstream ports enabled
  output reg         EXT_EXEC,       // Code runs from external flash
  output reg  [15:0] EXEC_ADDR,      // Execution start address
  output reg  [15:0] CONFIG,         // Applied configuration
  output reg         MGMT_SLAVE,     // Management bus in slave mode
  output reg         USB_CONNECT,    // Upstream connect asserted
  output reg         SUSPEND,        // Hub suspended
  output reg  [7:0]  GPIO_OUT,       // GPIO state
  output reg  [7:0]  BRIDGE_WOUT,    // Data to bridged device
  output reg  [7:0]  BRIDGE_RDATA,   // Data returned to host
  output reg  [9:0]  STAGE           // One-hot boot stage
);

  // ========================================================================
  // Stage encoding
  localparam [9:0] S_INIT    = 10'h001;
  localparam [9:0] S_SPI     = 10'h002;
  localparam [9:0] S_CFG_RD  = 10'h004;
  localparam [9:0] S_STRAP   = 10'h008;
  localparam [9:0] S_SOC     = 10'h010;
  localparam [9:0] S_OTP     = 10'h020;
  localparam [9:0] S_IDLE    = 10'h040;
  localparam [9:0] S_CHG     = 10'h080;
  localparam [9:0] S_CONNECT = 10'h100;
  localparam [9:0] S_NORMAL  = 10'h200;

  localparam integer LOCK_CYC_I = (`HBSS_LOCK_NS + `HBSS_CLK_NS - 1) / `HBSS_CLK_NS;
  localparam [7:0]   LOCK_CYC   = LOCK_CYC_I[7:0];

  // Flash read is opcode, 16-bit address, then four signature bytes
  localparam [6:0] SPI_HDR    = 7'h18;
  localparam [6:0] SPI_DBITS  = 7'h20;

  reg [9:0]  state;
  reg [9:0]  next_state;
  reg [7:0]  lock_cnt;
  reg        locked;
  reg [6:0]  bit_cnt;
  reg [23:0] hdr_shift;
  reg [31:0] sig_shift;
  reg        spi_done;
  reg        spi_half;
  reg [15:0] soc_cfg;
  reg [15:0] soc_mask;
  reg        soc_done;
  reg        spi_prime;

  wire       sig_ok  = (sig_shift == `HBSS_SIG_WORD);
  // Closing write is acted on at once so the stage ends on the edge that takes it
  wire       soc_fin = SOC_WR && (SOC_ADDR == `HBSS_SOC_DONE_ADDR);
  wire [7:0] opcode;

  // Strap-overridden value on top of a base word
  function [15:0] overlay;
    input [15:0] base;
    input [15:0] val;
    input [15:0] msk;
    begin
      overlay = (base & ~msk) | (val & msk);
    end
  endfunction

  // Slave preset decode, shared by the stage choice and the bus mode flag
  function is_slave_preset;
    input [2:0] code;
    begin
      is_slave_preset = (code == `HBSS_PRESET_SLAVE);
    end
  endfunction

  // Read opcode for the chosen data width
  function [7:0] read_opcode;
    input dual;
    begin
      read_opcode = dual ? `HBSS_OP_READ2 : `HBSS_OP_READ1;
    end
  endfunction

  assign opcode = read_opcode(SPI_DUAL);

  // ========================================================================
  // Stage transitions
  always @* begin
    next_state = state;
    case (state)
      S_INIT: begin
        if (locked)
          next_state = SPI_MODE_STRAP ? S_SPI : S_CFG_RD;
      end
      S_SPI: begin
        if (spi_done && !sig_ok)
          next_state = S_CFG_RD;
      end
      S_CFG_RD:
        next_state = S_STRAP;
      S_STRAP: begin
        if (is_slave_preset(PRESET_STRAP) && MGMT_DATA_IN && MGMT_CLOCK_IN)
          next_state = S_SOC;
        else
          next_state = S_OTP;
      end
      S_SOC: begin
        if (soc_done || soc_fin)
          next_state = S_OTP;
      end
      S_OTP:
        next_state = S_IDLE;
      S_IDLE: begin
        if (VBUS)
          next_state = BC_EN ? S_CHG : S_CONNECT;
      end
      S_CHG: begin
        if (CHG_DONE)
          next_state = S_CONNECT;
      end
      S_CONNECT: begin
        if (!VBUS)
          next_state = S_IDLE;
        else
          next_state = S_NORMAL;
      end
      S_NORMAL: begin
        if (MODE_CHANGE)
          next_state = S_IDLE;
      end
      default:
        next_state = S_INIT;
    endcase
  end

  // ========================================================================
  // Sequencer and configuration; everything returns to defaults in standby
  always @(posedge REF_CLK or posedge RESET) begin
    if (RESET) begin
      state       <= S_INIT;
      lock_cnt    <= 8'h00;
      locked      <= 1'b0;
      PLL_EN      <= 1'b0;
      PORT_OE     <= 1'b0;
      PORTS_EN    <= 1'b0;
      EXT_EXEC    <= 1'b0;
      EXEC_ADDR   <= `HBSS_EXEC_ADDR;
      CONFIG      <= `HBSS_ROM_DEFAULT;
      MGMT_SLAVE  <= 1'b0;
      soc_cfg     <= `HBSS_ROM_DEFAULT;
      soc_mask    <= 16'h0000;
      soc_done    <= 1'b0;
      STAGE       <= S_INIT;
    end else begin
      state  <= next_state;
      STAGE  <= next_state;
      PLL_EN <= 1'b1;
      if (state == S_INIT && PLL_CLK_OK && !locked) begin
        // Lock only counts while a valid clock is seen
        if (lock_cnt == LOCK_CYC - 8'h01)
          locked <= 1'b1;
        else
          lock_cnt <= lock_cnt + 8'h01;
      end
      if (state == S_SPI && spi_done && sig_ok) begin
        EXT_EXEC  <= 1'b1;
        EXEC_ADDR <= `HBSS_EXEC_ADDR;
      end
      if (state == S_CFG_RD) begin
        PORT_OE <= 1'b1;
        CONFIG  <= overlay(`HBSS_ROM_DEFAULT, STRAP_CFG, STRAP_MASK);
      end
      if (state == S_STRAP)
        MGMT_SLAVE <= is_slave_preset(PRESET_STRAP);
      if (state == S_SOC && SOC_WR) begin
        if (SOC_ADDR == `HBSS_SOC_DONE_ADDR)
          soc_done <= 1'b1;
        else begin
          soc_cfg  <= SOC_DATA;
          soc_mask <= 16'hFFFF;
        end
      end
      if (state == S_OTP) begin
        CONFIG   <= overlay(overlay(CONFIG, soc_cfg, soc_mask), OTP_DATA, OTP_VALID);
        PORTS_EN <= 1'b1;
      end
    end
  end

  // ========================================================================
  // Flash signature read; serial out on io0, data in on one or two lines
  always @(posedge REF_CLK or posedge RESET) begin
    if (RESET) begin
      SPI_SCK     <= 1'b0;
      SPI_CS_N    <= 1'b1;
      SPI_IO0_OUT <= 1'b0;
      SPI_IO0_OE  <= 1'b0;
      bit_cnt     <= 7'h00;
      hdr_shift   <= 24'h000000;
      sig_shift   <= 32'h00000000;
      spi_done    <= 1'b0;
      spi_half    <= 1'b0;
      spi_prime   <= 1'b0;
    end else if (state == S_SPI && !spi_done) begin
      if (SPI_CS_N) begin
        SPI_CS_N    <= 1'b0;
        SPI_SCK     <= SPI_CPOL;
        hdr_shift   <= {opcode, `HBSS_SIG_ADDR};
        SPI_IO0_OE  <= 1'b1;
        SPI_IO0_OUT <= opcode[7];
        bit_cnt     <= 7'h00;
        spi_half    <= 1'b0;
        spi_prime   <= SPI_CPOL;
      end else if (spi_prime) begin
        // Mode 3 rests high: one extra falling edge first, so that both
        // modes then rise to sample and fall to shift, never on one edge
        SPI_SCK   <= 1'b0;
        spi_prime <= 1'b0;
      end else begin
        spi_half <= ~spi_half;
        SPI_SCK  <= ~spi_half;
        if (!spi_half) begin
          // Leading edge: sample data in the read phase
          if (bit_cnt >= SPI_HDR) begin
            if (SPI_DUAL)
              sig_shift <= {sig_shift[29:0], SPI_MISO, SPI_IO0_IN};
            else
              sig_shift <= {sig_shift[30:0], SPI_MISO};
          end
        end else begin
          // Trailing edge: shift out next header bit or finish
          if (bit_cnt < SPI_HDR) begin
            hdr_shift   <= {hdr_shift[22:0], 1'b0};
            SPI_IO0_OUT <= hdr_shift[22];
            if (bit_cnt == SPI_HDR - 7'h01)
              SPI_IO0_OE <= ~SPI_DUAL;
            bit_cnt <= bit_cnt + 7'h01;
          end else if (bit_cnt == SPI_HDR + (SPI_DUAL ? SPI_DBITS >> 1 : SPI_DBITS) - 7'h01) begin
            SPI_CS_N   <= 1'b1;
            SPI_SCK    <= SPI_CPOL;
            SPI_IO0_OE <= 1'b0;
            spi_done   <= 1'b1;
          end else
            bit_cnt <= bit_cnt + 7'h01;
        end
      end
    end else begin
      // Clock rests at its idle level outside the frame
      SPI_SCK <= SPI_CPOL;
    end
  end

  // ========================================================================
  // Suspend and connect follow the stage being entered
  always @(posedge REF_CLK or posedge RESET) begin
    if (RESET) begin
      USB_CONNECT <= 1'b0;
      SUSPEND     <= 1'b0;
    end else begin
      SUSPEND     <= (next_state == S_IDLE);
      // Connect drops with VBUS even in normal mode, the stage stays put
      USB_CONNECT <= (next_state == S_CONNECT || next_state == S_NORMAL) && VBUS;
    end
  end

  // ========================================================================
  // Runtime GPIO writes and transparent bridging; data is not interpreted
  always @(posedge REF_CLK or posedge RESET) begin
    if (RESET) begin
      GPIO_OUT     <= 8'h00;
      BRIDGE_WOUT  <= 8'h00;
      BRIDGE_RDATA <= 8'h00;
    end else begin
      if (GPIO_WR && (state == S_SOC || state == S_NORMAL))
        GPIO_OUT <= GPIO_WDATA;
      if (BRIDGE_REQ && state == S_NORMAL) begin
        BRIDGE_WOUT  <= BRIDGE_WDATA;
        BRIDGE_RDATA <= BRIDGE_RDATA_IN;
      end
    end
  end

endmodule // hbss_sequencer
